/* rtl/ch_cond_regs.svh */
// constants of the channel input conditioning register bank
`ifndef CH_COND_REGS_SVH
`define CH_COND_REGS_SVH

// ****************************************************************
// address map
// ****************************************************************
`define CH_REGION_TOP 3'h0
`define OFF_STAT_EN 4'h0
`define OFF_FILTER 4'h1
`define OFF_GLITCH 4'h2
`define OFF_STATUS 4'h3
`define OFF_LOW_HI 4'h4
`define OFF_LOW_LO 4'h5
`define OFF_HIGH_HI 4'h6
`define OFF_HIGH_LO 4'h7
`define OFF_PRESET_B3 4'h8
`define OFF_PRESET_B2 4'h9
`define OFF_PRESET_B1 4'ha
`define OFF_PRESET_B0 4'hb
`define ADDR_MONITOR 8'h20
`define ADDR_SUPERVISORY 8'h21

// ****************************************************************
// field positions
// ****************************************************************
`define EN_BIT0 0
`define EN_BIT1 1
`define EN_BELOW_ABOVE 2
`define EN_AUX_LIMITS 3
`define FLT_CUTOFF_LSB 0
`define FLT_HB_BIT 4
`define FLT_ITP_BIT 5

// ****************************************************************
// reset values
// ****************************************************************
`define RST_STAT_EN 4'h0
`define RST_CUTOFF 4'h0
`define RST_HB 1'h0
`define RST_ITP 1'h0
`define RST_GLITCH 4'h7
`define RST_LOW_LIMIT 16'h8000
`define RST_HIGH_LIMIT 16'h7fff
`define RST_FLAGS 8'h00
`define RST_PRESET 32'h0000_0000

// ****************************************************************
// codes and timing
// ****************************************************************
`define CUTOFF_MAX 4'hc
`define CUTOFF_MIN_NON_VOLTAGE 4'h2
`define GF_CLK_HZ 40000000
`define GF_BASE_HZ 8000000
`define GF_TOP_SHORT 8'h7f
`define GF_TOP_FULL 8'hff
`define GF_SHORT_SETTING 4'h1
`define GF_BASE_SETTING 4'h2

`endif

/* rtl/ch_cond_pkg.sv */
// types shared by the channel input conditioning bank
`default_nettype none
package ch_cond_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] code_t;
  typedef logic [15:0] sample_t;
  typedef logic [31:0] preset_t;
  typedef logic [6:0] status_t;
endpackage : ch_cond_pkg
`default_nettype wire

/* rtl/sticky_flags.sv */
// set-on-event flags that clear when their register is read
`default_nettype none
module sticky_flags #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // events and read clear
  input wire logic [W-1:0] set,
  input wire logic clear,
  // flags
  output logic [W-1:0] flags
);
  // a set arriving with the read clear survives into the next read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags <= '0;
    end else begin
      flags <= (clear ? '0 : flags) | set;
    end
  end
endmodule : sticky_flags
`default_nettype wire

/* rtl/glitch_filter.sv */
// up/down counting spike filter for one digital input
`include "ch_cond_regs.svh"
`default_nettype none
module glitch_filter (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // synchronised input and setting
  input wire logic din,
  input wire logic [3:0] setting,
  // filtered output
  output logic dout
);
  import ch_cond_pkg::*;
  localparam int DIV = `GF_CLK_HZ / `GF_BASE_HZ;

  logic [2:0] div_cnt;
  logic base_tick;
  logic [12:0] rate_cnt;
  logic [12:0] rate_mask;
  logic sample_tick;
  logic [7:0] cnt;
  logic [7:0] top;

  // ****************************************************************
  // sample clock: 8 MHz base, halved per setting step above 2
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 3'h0;
      base_tick <= 1'b0;
    end else if (div_cnt == 3'(DIV - 1)) begin
      div_cnt <= 3'h0;
      base_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 3'h1;
      base_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rate_cnt <= 13'h0000;
    end else if (base_tick) begin
      rate_cnt <= rate_cnt + 13'h0001;
    end
  end

  always_comb begin
    rate_mask = 13'h0000;
    if (setting > `GF_BASE_SETTING) begin
      rate_mask = 13'((14'h0001 << (setting - `GF_BASE_SETTING)) - 14'h0001);
    end
    sample_tick = base_tick && ((rate_cnt & rate_mask) == rate_mask);
    top = (setting == `GF_SHORT_SETTING) ? `GF_TOP_SHORT : `GF_TOP_FULL;
  end

  // ****************************************************************
  // counter and output
  // ****************************************************************
  // free-running sample phase: the filter time is exact to one sample
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 8'h00;
      dout <= 1'b0;
    end else if (setting == 4'h0) begin
      cnt <= 8'h00;
      dout <= din;
    end else if (cnt > top) begin
      cnt <= top;
    end else if (sample_tick) begin
      if (din && cnt != top) begin
        cnt <= cnt + 8'h01;
        if (cnt + 8'h01 == top) begin
          dout <= 1'b1;
        end
      end else if (!din && cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
        if (cnt == 8'h01) begin
          dout <= 1'b0;
        end
      end
    end
  end
endmodule : glitch_filter
`default_nettype wire

/* rtl/channel_input_conditioning_regs.sv */
// per-channel input conditioning configuration and status registers
`include "ch_cond_regs.svh"
`default_nettype none
module channel_input_conditioning_regs (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // register access from the serial host port decoder
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire ch_cond_pkg::byte_t REG_ADDR,
  input wire ch_cond_pkg::byte_t REG_WDATA,
  output ch_cond_pkg::byte_t REG_RDATA,
  output logic REG_RVALID,
  // digital input pins, one per channel
  input wire logic [1:0] DIN_RAW,
  output logic [1:0] DIN_FILT,
  // converter samples, one per channel
  input wire ch_cond_pkg::sample_t AI_SAMPLE_0,
  input wire ch_cond_pkg::sample_t AI_SAMPLE_1,
  input wire logic [1:0] AI_VALID,
  input wire logic [1:0] VOLTAGE_MODE,
  // other status events, two per channel, and aux limit events, three per channel
  input wire logic [3:0] STATUS_EVENT,
  input wire logic [5:0] AUX_LIMIT_EVENT,
  // converter filter control
  output ch_cond_pkg::code_t CUTOFF_0,
  output ch_cond_pkg::code_t CUTOFF_1,
  output logic [1:0] HB_BYPASS,
  output logic [1:0] ITP_BYPASS,
  // channel status to the flag aggregation
  output ch_cond_pkg::status_t CHANNEL_STATUS_0,
  output ch_cond_pkg::status_t CHANNEL_STATUS_1,
  // counter preset
  input wire logic [1:0] PWM_MODE,
  output ch_cond_pkg::preset_t PRESET_0,
  output ch_cond_pkg::preset_t PRESET_1,
  output logic [1:0] PRESET_LOAD,
  output logic [1:0] PRESET_LOW_ONLY,
  // fault levels from the analog monitors
  input wire logic [3:0] INT_FAULT,
  input wire ch_cond_pkg::byte_t SUPV_FAULT,
  output ch_cond_pkg::byte_t SUPERVISORY_FLAGS
);
  import ch_cond_pkg::*;

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic logic ch_hit(input byte_t addr, input int ch, input logic [3:0] off);
    ch_hit = (addr[7:5] == `CH_REGION_TOP) && (addr[4] == ch[0]) && (addr[3:0] == off);
  endfunction : ch_hit

  logic [3:0] stat_en [2];
  code_t cutoff [2];
  logic hb [2];
  logic itp [2];
  code_t glitch_time [2];
  sample_t low_limit [2];
  sample_t high_limit [2];
  status_t status [2];
  sample_t sample [2];
  logic [1:0] din_s1;
  logic [1:0] din_s2;
  logic [3:0] int_s1;
  logic [3:0] int_s2;
  byte_t supv_s1;
  byte_t supv_s2;
  logic [3:0] monitor;
  byte_t supervisory;
  byte_t next_rdata;

  assign sample[0] = AI_SAMPLE_0;
  assign sample[1] = AI_SAMPLE_1;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      din_s1 <= 2'h0;
      din_s2 <= 2'h0;
      int_s1 <= 4'h0;
      int_s2 <= 4'h0;
      supv_s1 <= 8'h00;
      supv_s2 <= 8'h00;
    end else begin
      din_s1 <= DIN_RAW;
      din_s2 <= din_s1;
      int_s1 <= INT_FAULT;
      int_s2 <= int_s1;
      supv_s1 <= SUPV_FAULT;
      supv_s2 <= supv_s1;
    end
  end

  // ****************************************************************
  // per-channel logic
  // ****************************************************************
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic stat_rd;
    logic below;
    logic above;
    status_t stat_set;
    preset_t stage;
    logic upper_written;
    code_t next_cutoff;

    // configuration writes
    always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
        stat_en[c] <= `RST_STAT_EN;
        cutoff[c] <= `RST_CUTOFF;
        hb[c] <= `RST_HB;
        itp[c] <= `RST_ITP;
        glitch_time[c] <= `RST_GLITCH;
      end else if (REG_WR) begin
        if (ch_hit(REG_ADDR, c, `OFF_STAT_EN)) begin
          stat_en[c] <= REG_WDATA[3:0];
        end
        if (ch_hit(REG_ADDR, c, `OFF_FILTER)) begin
          cutoff[c] <= REG_WDATA[`FLT_CUTOFF_LSB +: 4];
          hb[c] <= REG_WDATA[`FLT_HB_BIT];
          itp[c] <= REG_WDATA[`FLT_ITP_BIT];
        end
        if (ch_hit(REG_ADDR, c, `OFF_GLITCH)) begin
          glitch_time[c] <= REG_WDATA[3:0];
        end
      end
    end

    // limits are written a byte at a time
    always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
        low_limit[c] <= `RST_LOW_LIMIT;
        high_limit[c] <= `RST_HIGH_LIMIT;
      end else if (REG_WR) begin
        if (ch_hit(REG_ADDR, c, `OFF_LOW_HI)) begin
          low_limit[c][15:8] <= REG_WDATA;
        end
        if (ch_hit(REG_ADDR, c, `OFF_LOW_LO)) begin
          low_limit[c][7:0] <= REG_WDATA;
        end
        if (ch_hit(REG_ADDR, c, `OFF_HIGH_HI)) begin
          high_limit[c][15:8] <= REG_WDATA;
        end
        if (ch_hit(REG_ADDR, c, `OFF_HIGH_LO)) begin
          high_limit[c][7:0] <= REG_WDATA;
        end
      end
    end

    // cut-off code to the converter filter
    always_comb begin
      next_cutoff = (cutoff[c] > `CUTOFF_MAX) ? `CUTOFF_MAX : cutoff[c];
      // the two widest bypass bands are unusable outside voltage measurement
      if (hb[c] && !VOLTAGE_MODE[c] && next_cutoff < `CUTOFF_MIN_NON_VOLTAGE) begin
        next_cutoff = `CUTOFF_MIN_NON_VOLTAGE;
      end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
        HB_BYPASS[c] <= `RST_HB;
        ITP_BYPASS[c] <= `RST_ITP;
      end else begin
        HB_BYPASS[c] <= hb[c];
        ITP_BYPASS[c] <= itp[c];
      end
    end

    if (c == 0) begin : g_cut0
      always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          CUTOFF_0 <= `RST_CUTOFF;
        end else begin
          CUTOFF_0 <= next_cutoff;
        end
      end
    end else begin : g_cut1
      always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          CUTOFF_1 <= `RST_CUTOFF;
        end else begin
          CUTOFF_1 <= next_cutoff;
        end
      end
    end

    // window check on signed samples; limits are the last valid values
    always_comb begin
      below = AI_VALID[c] && ($signed(sample[c]) < $signed(low_limit[c]));
      above = AI_VALID[c] && ($signed(sample[c]) > $signed(high_limit[c]));
      stat_set[0] = STATUS_EVENT[2*c] && stat_en[c][`EN_BIT0];
      stat_set[1] = STATUS_EVENT[2*c+1] && stat_en[c][`EN_BIT1];
      stat_set[2] = below && stat_en[c][`EN_BELOW_ABOVE];
      stat_set[3] = above && stat_en[c][`EN_BELOW_ABOVE];
      stat_set[6:4] = AUX_LIMIT_EVENT[3*c +: 3] & {3{stat_en[c][`EN_AUX_LIMITS]}};
    end

    assign stat_rd = REG_RD && ch_hit(REG_ADDR, c, `OFF_STATUS);

    sticky_flags #(
      .W(7)
    ) u_status (
      .clk(CLK),
      .rst_b(RST_B),
      .set(stat_set),
      .clear(stat_rd),
      .flags(status[c])
    );

    glitch_filter u_glitch (
      .clk(CLK),
      .rst_b(RST_B),
      .din(din_s2[c]),
      .setting(glitch_time[c]),
      .dout(DIN_FILT[c])
    );

    // counter preset: bytes stage, the last byte commits the word
    always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
        stage <= `RST_PRESET;
        upper_written <= 1'b0;
        PRESET_LOAD[c] <= 1'b0;
        PRESET_LOW_ONLY[c] <= 1'b0;
      end else begin
        PRESET_LOAD[c] <= 1'b0;
        PRESET_LOW_ONLY[c] <= 1'b0;
        if (REG_WR) begin
          if (ch_hit(REG_ADDR, c, `OFF_PRESET_B3)) begin
            stage[31:24] <= REG_WDATA;
            upper_written <= 1'b1;
          end
          if (ch_hit(REG_ADDR, c, `OFF_PRESET_B2)) begin
            stage[23:16] <= REG_WDATA;
            upper_written <= 1'b1;
          end
          if (ch_hit(REG_ADDR, c, `OFF_PRESET_B1)) begin
            stage[15:8] <= REG_WDATA;
          end
          if (ch_hit(REG_ADDR, c, `OFF_PRESET_B0)) begin
            stage[7:0] <= REG_WDATA;
            upper_written <= 1'b0;
            // a lower-half-only write is dropped outside the PWM modes
            PRESET_LOAD[c] <= upper_written || PWM_MODE[c];
            PRESET_LOW_ONLY[c] <= !upper_written && PWM_MODE[c];
          end
        end
      end
    end

    if (c == 0) begin : g_pre0
      always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          PRESET_0 <= `RST_PRESET;
        end else if (REG_WR && ch_hit(REG_ADDR, c, `OFF_PRESET_B0)) begin
          if (upper_written) begin
            PRESET_0 <= {stage[31:8], REG_WDATA};
          end else if (PWM_MODE[c]) begin
            PRESET_0[15:0] <= {stage[15:8], REG_WDATA};
          end
        end
      end
      always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          CHANNEL_STATUS_0 <= 7'h00;
        end else begin
          CHANNEL_STATUS_0 <= status[c];
        end
      end
    end else begin : g_pre1
      always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          PRESET_1 <= `RST_PRESET;
        end else if (REG_WR && ch_hit(REG_ADDR, c, `OFF_PRESET_B0)) begin
          if (upper_written) begin
            PRESET_1 <= {stage[31:8], REG_WDATA};
          end else if (PWM_MODE[c]) begin
            PRESET_1[15:0] <= {stage[15:8], REG_WDATA};
          end
        end
      end
      always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          CHANNEL_STATUS_1 <= 7'h00;
        end else begin
          CHANNEL_STATUS_1 <= status[c];
        end
      end
    end
  end

  // ****************************************************************
  // internal monitor and supervisory flags
  // ****************************************************************
  // the monitor flags go to the read mux only, never to status or flags
  sticky_flags #(
    .W(4)
  ) u_monitor (
    .clk(CLK),
    .rst_b(RST_B),
    .set(int_s2),
    .clear(REG_RD && REG_ADDR == `ADDR_MONITOR),
    .flags(monitor)
  );

  sticky_flags #(
    .W(8)
  ) u_supervisory (
    .clk(CLK),
    .rst_b(RST_B),
    .set(supv_s2),
    .clear(REG_RD && REG_ADDR == `ADDR_SUPERVISORY),
    .flags(supervisory)
  );

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      SUPERVISORY_FLAGS <= `RST_FLAGS;
    end else begin
      SUPERVISORY_FLAGS <= supervisory;
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  // the preset is write-only and reads as zero like any unmapped byte
  always_comb begin
    next_rdata = 8'h00;
    if (REG_ADDR == `ADDR_MONITOR) begin
      next_rdata = {4'h0, monitor};
    end else if (REG_ADDR == `ADDR_SUPERVISORY) begin
      next_rdata = supervisory;
    end else if (REG_ADDR[7:5] == `CH_REGION_TOP) begin
      case (REG_ADDR[3:0])
        `OFF_STAT_EN: next_rdata = {4'h0, stat_en[REG_ADDR[4]]};
        `OFF_FILTER: next_rdata = {2'h0, itp[REG_ADDR[4]], hb[REG_ADDR[4]],
                                   cutoff[REG_ADDR[4]]};
        `OFF_GLITCH: next_rdata = {4'h0, glitch_time[REG_ADDR[4]]};
        `OFF_STATUS: next_rdata = {1'b0, status[REG_ADDR[4]]};
        `OFF_LOW_HI: next_rdata = low_limit[REG_ADDR[4]][15:8];
        `OFF_LOW_LO: next_rdata = low_limit[REG_ADDR[4]][7:0];
        `OFF_HIGH_HI: next_rdata = high_limit[REG_ADDR[4]][15:8];
        `OFF_HIGH_LO: next_rdata = high_limit[REG_ADDR[4]][7:0];
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= next_rdata;
      end
    end
  end
endmodule : channel_input_conditioning_regs
`default_nettype wire

/* verif/ch_cond_regs_assertions.sv */
// concurrent checks on the ports of the channel input conditioning bank
`default_nettype none
module ch_cond_regs_checker (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // register access
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire ch_cond_pkg::byte_t REG_ADDR,
  input wire logic REG_RVALID,
  // analog path and filter control
  input wire logic [1:0] AI_VALID,
  input wire logic [1:0] VOLTAGE_MODE,
  input wire ch_cond_pkg::code_t CUTOFF_0,
  input wire logic [1:0] HB_BYPASS,
  input wire ch_cond_pkg::status_t CHANNEL_STATUS_0,
  // counter preset
  input wire logic [1:0] PWM_MODE,
  input wire ch_cond_pkg::preset_t PRESET_0,
  input wire logic [1:0] PRESET_LOAD,
  input wire logic [1:0] PRESET_LOW_ONLY,
  // supervisory
  input wire ch_cond_pkg::byte_t SUPERVISORY_FLAGS
);
  import ch_cond_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_read_answer: assert property (REG_RVALID == $past(REG_RD))
    else $error("read answer not exactly one cycle after the read strobe");
  a_cutoff_capped: assert property (CUTOFF_0 <= 4'hc)
    else $error("cut-off code above the last defined step");
  a_fast_voltage_only: assert property (
    HB_BYPASS[0] && !VOLTAGE_MODE[0] && $past(!VOLTAGE_MODE[0]) |-> CUTOFF_0 >= 4'h2)
    else $error("top bypass cut-off used without voltage measurement");
  a_low_half_pwm: assert property (
    PRESET_LOW_ONLY[0] |-> PRESET_LOAD[0] && $past(PWM_MODE[0]))
    else $error("lower-half preset load outside pwm mode");
  a_load_last_byte: assert property (
    PRESET_LOAD[0] |-> $past(REG_WR && REG_ADDR == 8'h0b))
    else $error("preset committed without a write of its last byte");
  a_preset_held: assert property (!PRESET_LOAD[0] |-> $stable(PRESET_0))
    else $error("preset word changed without a load");
  a_above_cause: assert property (
    $rose(CHANNEL_STATUS_0[3]) |-> $past(AI_VALID[0], 2))
    else $error("window flag rose without a sample");
  a_supv_read_clear: assert property (
    $fell(SUPERVISORY_FLAGS[0]) |-> $past(REG_RD && REG_ADDR == 8'h21, 2))
    else $error("supervisory flag dropped without a read");
endmodule : ch_cond_regs_checker

bind channel_input_conditioning_regs ch_cond_regs_checker i_checker (
  .CLK(CLK), .RST_B(RST_B), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
  .REG_RVALID(REG_RVALID), .AI_VALID(AI_VALID), .VOLTAGE_MODE(VOLTAGE_MODE),
  .CUTOFF_0(CUTOFF_0), .HB_BYPASS(HB_BYPASS), .CHANNEL_STATUS_0(CHANNEL_STATUS_0),
  .PWM_MODE(PWM_MODE), .PRESET_0(PRESET_0), .PRESET_LOAD(PRESET_LOAD),
  .PRESET_LOW_ONLY(PRESET_LOW_ONLY), .SUPERVISORY_FLAGS(SUPERVISORY_FLAGS));
`default_nettype wire

/* verif/host_port_model.sv */
// register port host standing in for the serial port decoder
`default_nettype none
module host_port_model (
  // clock
  input wire logic clk,
  // register access
  output logic reg_wr,
  output logic reg_rd,
  output ch_cond_pkg::byte_t reg_addr,
  output ch_cond_pkg::byte_t reg_wdata,
  input wire ch_cond_pkg::byte_t reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  import ch_cond_pkg::*;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // strobe stays high so that consecutive calls form a burst
  task automatic wr(input byte_t a, input byte_t d);
    @(negedge clk);
    reg_rd = 1'b0;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
  endtask : wr
  // released lines show the inverse so a stale value is never trusted
  task automatic idle();
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : idle
  task automatic rd(input byte_t a, output byte_t d, output logic v);
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    v = reg_rvalid;
  endtask : rd
endmodule : host_port_model
`default_nettype wire

/* verif/testbench.sv */
// self-checking testbench of the channel input conditioning register bank
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ch_cond_pkg::*;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
  // one filter step is five clocks: 8 MHz sampling from 40 MHz
  localparam int GF_RISE = 127 * 5;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr, reg_rd, reg_rvalid;
  byte_t reg_addr, reg_wdata, reg_rdata, supv;
  logic [1:0] din_raw = '0, ai_valid = '0, vmode = '0, pwm = '0;
  logic [1:0] din_filt, hb, itp, pload, plow;
  sample_t ai0 = '0, ai1 = '0;
  logic [3:0] sev = '0, ifault = '0;
  logic [5:0] aux = '0;
  byte_t sfault = '0;
  code_t co0, co1;
  status_t st0, st1;
  preset_t pr0, pr1;
  int n_errors = 0;
  int n_checks = 0;
  byte_t rst_tab [8] = '{8'h00, 8'h00, 8'h07, 8'h00, 8'h80, 8'h00, 8'h7f, 8'hff};

  always #12.5 clk = ~clk;

  host_port_model i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  channel_input_conditioning_regs i_dut (.CLK(clk), .RST_B(rst_b), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .REG_RVALID(reg_rvalid), .DIN_RAW(din_raw), .DIN_FILT(din_filt), .AI_SAMPLE_0(ai0),
    .AI_SAMPLE_1(ai1), .AI_VALID(ai_valid), .VOLTAGE_MODE(vmode), .STATUS_EVENT(sev),
    .AUX_LIMIT_EVENT(aux), .CUTOFF_0(co0), .CUTOFF_1(co1), .HB_BYPASS(hb),
    .ITP_BYPASS(itp), .CHANNEL_STATUS_0(st0), .CHANNEL_STATUS_1(st1), .PWM_MODE(pwm),
    .PRESET_0(pr0), .PRESET_1(pr1), .PRESET_LOAD(pload), .PRESET_LOW_ONLY(plow),
    .INT_FAULT(ifault), .SUPV_FAULT(sfault), .SUPERVISORY_FLAGS(supv));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  task automatic rdc(input byte_t a, input byte_t e);
    byte_t d;
    logic v;
    i_host.rd(a, d, v);
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask : rdc

  // a settled output needs one more cycle after the write is taken
  task automatic wr1(input byte_t a, input byte_t d);
    i_host.wr(a, d);
    i_host.idle();
    @(negedge clk);
  endtask : wr1

  task automatic ev(input logic [1:0] s, input logic [2:0] a, input sample_t x);
    @(negedge clk);
    sev[1:0] = s;
    aux[2:0] = a;
    ai0 = x;
    ai_valid[0] = 1'b1;
    @(negedge clk);
    sev = '0;
    aux = '0;
    ai_valid = '0;
  endtask : ev

  // burst of the last n bytes of a preset word, most significant first
  task automatic wpre(input byte_t base, input preset_t w, input int n);
    for (int i = 4 - n; i < 4; i++) begin
      i_host.wr(base + 8'(8 + i), w[31 - 8 * i -: 8]);
    end
    i_host.idle();
  endtask : wpre

  initial begin
    #250000;
    n_errors++;
    complete_run();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    foreach (rst_tab[i]) for (int c = 0; c < 2; c++) rdc(8'(16 * c + i), rst_tab[i]);
    rdc(8'h08, 8'h00);
    rdc(8'h3f, 8'h00);
    $display("test reset_values done");

    wr1(8'h01, 8'h0d);
    `CHK(co0, 4'hc)
    wr1(8'h01, 8'h11);
    `CHK({hb[0], co0}, 5'h12)
    vmode[0] = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(co0, 4'h1)
    wr1(8'h01, 8'h20);
    `CHK({itp[0], hb[0], co0}, 6'h20)
    wr1(8'h11, 8'h0c);
    `CHK(co1, 4'hc)
    $display("test cutoff done");

    ev(2'b11, 3'b111, 16'h0020);
    rdc(8'h03, 8'h00);
    wr1(8'h00, 8'h0d);
    i_host.wr(8'h04, 8'h00);
    i_host.wr(8'h05, 8'h10);
    i_host.wr(8'h06, 8'h01);
    i_host.wr(8'h07, 8'h00);
    i_host.idle();
    ev(2'b11, 3'b001, 16'h0005);
    @(negedge clk);
    `CHK(st0, 7'h15)
    rdc(8'h03, 8'h15);
    rdc(8'h03, 8'h00);
    ev(2'b00, 3'b000, 16'h0200);
    rdc(8'h03, 8'h08);
    ev(2'b00, 3'b000, 16'h0100);
    rdc(8'h03, 8'h00);
    // low limit at the range minimum leaves only the upper check
    i_host.wr(8'h04, 8'h80);
    wr1(8'h05, 8'h00);
    ev(2'b00, 3'b000, 16'h8000);
    rdc(8'h03, 8'h00);
    $display("test status done");

    ifault = 4'b0101;
    sfault = 8'h81;
    repeat (4) @(negedge clk);
    ifault = '0;
    sfault = '0;
    repeat (4) @(negedge clk);
    `CHK({st1, st0}, 14'h0000)
    `CHK(supv, 8'h81)
    rdc(8'h20, 8'h05);
    rdc(8'h20, 8'h00);
    rdc(8'h21, 8'h81);
    rdc(8'h21, 8'h00);
    `CHK(supv, 8'h00)
    $display("test monitor done");

    wpre(8'h00, 32'h1234_5678, 4);
    `CHK({pload[0], pr0}, {1'b1, 32'h1234_5678})
    wpre(8'h00, 32'h0000_aabb, 2);
    `CHK({pload[0], pr0}, {1'b0, 32'h1234_5678})
    pwm[0] = 1'b1;
    wpre(8'h00, 32'h0000_ccdd, 2);
    `CHK({plow[0], pr0}, {1'b1, 32'h1234_ccdd})
    wpre(8'h10, 32'h9abc_def0, 4);
    `CHK(pr1, 32'h9abc_def0)
    rdc(8'h0b, 8'h00);
    $display("test preset done");

    wr1(8'h02, 8'h01);
    din_raw[0] = 1'b1;
    repeat (GF_RISE - 15) @(negedge clk);
    `CHK(din_filt[0], 1'b0)
    repeat (30) @(negedge clk);
    `CHK(din_filt[0], 1'b1)
    din_raw[0] = 1'b0;
    repeat (GF_RISE - 15) @(negedge clk);
    `CHK(din_filt[0], 1'b1)
    repeat (30) @(negedge clk);
    `CHK(din_filt[0], 1'b0)
    // setting 3 samples every ten clocks: 255 steps is about 2550 clocks
    wr1(8'h02, 8'h03);
    din_raw[0] = 1'b1;
    repeat (2525) @(negedge clk);
    `CHK(din_filt[0], 1'b0)
    repeat (50) @(negedge clk);
    `CHK(din_filt[0], 1'b1)
    din_raw[0] = 1'b0;
    wr1(8'h02, 8'h00);
    `CHK(din_filt[0], 1'b0)
    din_raw[0] = 1'b1;
    repeat (5) @(negedge clk);
    `CHK(din_filt[0], 1'b1)
    $display("test glitch done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
